// ---- design/dmc_pkg.sv ----
// Constants shared by the six-channel DMA controller and its users
package dmc_pkg;
    // ==================================================================
    // Sizes
    localparam int          NCH        = 6;
    localparam int          NWORDS     = 36;
    localparam int          NHWREQ     = 8;
    localparam int          NHWCH      = 4;
    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0]  REG_ENABLE = 8'h00;
    localparam logic [7:0]  REG_PRIO   = 8'h04;
    localparam logic [7:0]  REG_SWREQ  = 8'h08;
    localparam logic [7:0]  REG_ALT    = 8'h0c;
    localparam logic [7:0]  REG_DONE   = 8'h10;
    localparam logic [7:0]  REG_MASK   = 8'h14;
    localparam logic [7:0]  REG_STATUS = 8'h18;
    localparam logic [7:0]  DESC_BASE  = 8'h40;
    localparam logic [5:0]  DESC_WORDS = 6'h24;
    // ==================================================================
    // Descriptor layout: three words per structure, two structures per channel
    localparam logic [5:0]  W_CTRL     = 6'h0;
    localparam logic [5:0]  W_SRC      = 6'h1;
    localparam logic [5:0]  W_DST      = 6'h2;
    localparam int          CYC_LSB    = 0;
    localparam int          CYC_MSB    = 1;
    localparam int          RPW_LSB    = 2;
    localparam int          RPW_MSB    = 5;
    localparam int          NM1_LSB    = 6;
    localparam int          NM1_MSB    = 15;
    // ==================================================================
    // Cycle-control encodings
    localparam logic [1:0]  CYC_INVALID  = 2'h0;
    localparam logic [1:0]  CYC_BASIC    = 2'h1;
    localparam logic [1:0]  CYC_AUTO     = 2'h2;
    localparam logic [1:0]  CYC_PINGPONG = 2'h3;
    // ==================================================================
    // Address step per word transfer and reset values
    localparam logic [31:0] WORD_STEP  = 32'h4;
    localparam logic [5:0]  RST_CH6    = 6'h00;
endpackage : dmc_pkg

// ---- design/dmc_dma_top.sv ----
// Six-channel DMA controller: arbiter, descriptor store, transfer engine, registers
//
// Summary of operation
// - Six independent channels, each with its requests
// - Channels one to four take serial peripheral requests
// - Every channel also accepts a software request
// - Per-channel priority, high or default, steers arbitration
// - Channels five and six start by software only
// - Re-arbitrate after two-to-the-R transfers
// - Leftover transfers run at cycle end
// - Cycle-control field selects invalid/basic/auto/ping-pong
// - Completed structure is written back as invalid
// - Basic: one block per request, then wait
// - Completion pulses channel done for one clock
// - Basic and auto use primary or alternate structure
// - Auto: one request runs the whole cycle
// - Ping-pong stops on invalid, basic or disable
// - Ping-pong starts other structure at once
// - Higher priority channel served at each arbitration
`timescale 1ns/1ps
module dmc_dma_top (
    input  wire logic        CLK,                      // System clock, 40 MHz
    input  wire logic        RST,                      // Synchronous reset, active high
    input  wire logic [7:0]  REG_ADDR,                 // Register byte address
    input  wire logic [31:0] REG_WDATA,                // Register write data
    input  wire logic        REG_WR,                   // Register write strobe
    input  wire logic        REG_RD,                   // Register read strobe
    output logic      [31:0] REG_RDATA,                // Read data, cycle after strobe
    input  wire logic        SYNC_SERIAL_A_TX_REQUEST, // Channel 1 transmit request
    input  wire logic        SYNC_SERIAL_A_RX_REQUEST, // Channel 1 receive request
    input  wire logic        SYNC_SERIAL_B_TX_REQUEST, // Channel 2 transmit request
    input  wire logic        SYNC_SERIAL_B_RX_REQUEST, // Channel 2 receive request
    input  wire logic        SERIAL_PORT_A_TX_REQUEST, // Channel 3 transmit request
    input  wire logic        SERIAL_PORT_A_RX_REQUEST, // Channel 3 receive request
    input  wire logic        SERIAL_PORT_B_TX_REQUEST, // Channel 4 transmit request
    input  wire logic        SERIAL_PORT_B_RX_REQUEST, // Channel 4 receive request
    output logic      [31:0] MEM_ADDR,                 // Bus address
    output logic             MEM_RD,                   // Bus read strobe
    output logic             MEM_WR,                   // Bus write strobe
    output logic      [31:0] MEM_WDATA,                // Bus write data
    input  wire logic [31:0] MEM_RDATA,                // Bus read data, cycle after read
    output logic      [5:0]  DMA_DONE,                 // Per-channel completion pulse
    output logic             IRQ                       // Level interrupt
);
    // ==================================================================
    // State
    typedef enum logic [1:0] {S_IDLE, S_RD, S_HOLD, S_WR} dmc_st_e;

    typedef struct packed {
        dmc_st_e                  state;
        logic [2:0]               cur;
        logic [31:0]              src;
        logic [31:0]              dst;
        logic [9:0]               n;
        logic [15:0]              blk;
        logic [5:0]               en;
        logic [5:0]               pri;
        logic [5:0]               swp;
        logic [5:0]               alt;
        logic [5:0]               run;
        logic [5:0]               done_st;
        logic [5:0]               mask;
        logic [5:0]               done_p;
        logic [31:0]              rdata;
        logic                     mem_rd;
        logic                     mem_wr;
        logic [31:0]              maddr;
        logic [31:0]              mwdata;
        logic [7:0]               s1;
        logic [7:0]               s2;
        logic [35:0][31:0]        mem;
    } dmc_state_s;

    dmc_state_s q;
    dmc_state_s d;

    // ==================================================================
    // Helpers
    // Word index of a descriptor word
    function automatic logic [5:0] sidx(input logic [2:0] ch, input logic alt, input logic [5:0] w);
        sidx = ({3'h0, ch} * 6'h2 + {5'h0, alt}) * 6'h3 + w;
    endfunction : sidx

    // Lowest set bit of a channel vector
    function automatic logic [2:0] first_set(input logic [5:0] v);
        first_set = 3'h0;
        for (int i = dmc_pkg::NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction : first_set

    // Transfers per arbitration block
    function automatic logic [15:0] blksize(input logic [3:0] r);
        blksize = 16'h1 << r;
    endfunction : blksize

    // ==================================================================
    // Request gathering and arbitration
    logic [5:0] hw;
    logic [5:0] want;
    logic [5:0] hi;
    logic [5:0] grp;
    logic [2:0] pick;
    logic       grant;
    logic [5:0] ci;
    logic [1:0] cyc;
    logic [3:0] rpw;
    logic       fin;
    logic [5:0] sa;
    logic       sa_hit;

    // Hardware requests come from synchronised pins; channels five and six have none
    always_comb begin
        hw = '0;
        for (int c = 0; c < dmc_pkg::NHWCH; c++) begin
            hw[c] = q.s2[2*c] | q.s2[2*c+1];
        end
        // A channel wants service when it has a live structure and a reason to run
        want = '0;
        for (int c = 0; c < dmc_pkg::NCH; c++) begin
            logic [1:0] ct;
            ct = q.mem[sidx(3'(c), q.alt[c], dmc_pkg::W_CTRL)][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB];
            want[c] = q.en[c] && (ct != dmc_pkg::CYC_INVALID)
                      && (q.swp[c] || hw[c]
                          || (q.run[c] && (ct == dmc_pkg::CYC_AUTO || ct == dmc_pkg::CYC_PINGPONG)));
        end
        hi    = want & q.pri;
        grp   = (hi != '0) ? hi : want;
        pick  = first_set(grp);
        // Grants are only made at an arbitration point, with the engine idle
        grant = (q.state == S_IDLE) && (want != '0);
        ci    = sidx(q.cur, q.alt[q.cur], dmc_pkg::W_CTRL);
        cyc   = q.mem[ci][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB];
        rpw   = q.mem[ci][dmc_pkg::RPW_MSB:dmc_pkg::RPW_LSB];
        // Last word of the cycle is being written
        fin   = (q.state == S_WR) && (q.n == '0);
        // Descriptor word index of a register access
        sa    = REG_ADDR[7:2] - dmc_pkg::DESC_BASE[7:2];
        sa_hit = (REG_ADDR >= dmc_pkg::DESC_BASE) && (sa < dmc_pkg::DESC_WORDS);
    end

    // ==================================================================
    // Next state: registers, run flags, transfer engine
    // Engine write-back is applied after software writes, so it wins a same-cycle clash
    always_comb begin
        logic [5:0] gi;
        gi = sidx(pick, q.alt[pick], dmc_pkg::W_CTRL);
        d        = q;
        d.mem_rd = 1'b0;
        d.mem_wr = 1'b0;
        d.done_p = '0;
        d.rdata  = '0;
        // Request pins are asynchronous: two flops before any logic reads them
        d.s1     = {SERIAL_PORT_B_RX_REQUEST, SERIAL_PORT_B_TX_REQUEST,
                    SERIAL_PORT_A_RX_REQUEST, SERIAL_PORT_A_TX_REQUEST,
                    SYNC_SERIAL_B_RX_REQUEST, SYNC_SERIAL_B_TX_REQUEST,
                    SYNC_SERIAL_A_RX_REQUEST, SYNC_SERIAL_A_TX_REQUEST};
        d.s2     = q.s1;

        // Software writes
        if (REG_WR) begin
            case (REG_ADDR)
                dmc_pkg::REG_ENABLE: d.en   = REG_WDATA[5:0];
                dmc_pkg::REG_PRIO:   d.pri  = REG_WDATA[5:0];
                dmc_pkg::REG_ALT:    d.alt  = REG_WDATA[5:0];
                dmc_pkg::REG_MASK:   d.mask = REG_WDATA[5:0];
                default: begin
                    if (sa_hit) begin
                        d.mem[sa] = REG_WDATA;
                    end
                end
            endcase
        end

        // Software reads; a read of the done status clears it
        if (REG_RD) begin
            case (REG_ADDR)
                dmc_pkg::REG_ENABLE: d.rdata = {26'h0, q.en};
                dmc_pkg::REG_PRIO:   d.rdata = {26'h0, q.pri};
                dmc_pkg::REG_SWREQ:  d.rdata = {26'h0, q.swp};
                dmc_pkg::REG_ALT:    d.rdata = {26'h0, q.alt};
                dmc_pkg::REG_MASK:   d.rdata = {26'h0, q.mask};
                dmc_pkg::REG_STATUS: d.rdata = {28'h0, q.state != S_IDLE, q.cur};
                dmc_pkg::REG_DONE: begin
                    d.rdata   = {26'h0, q.done_st};
                    d.done_st = '0;
                end
                default: begin
                    if (sa_hit) begin
                        d.rdata = q.mem[sa];
                    end
                end
            endcase
        end

        // Self-running channels drop out when disabled, invalid or switched to basic
        for (int c = 0; c < dmc_pkg::NCH; c++) begin
            logic [1:0] ct;
            ct = q.mem[sidx(3'(c), q.alt[c], dmc_pkg::W_CTRL)][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB];
            if (!q.en[c] || ct == dmc_pkg::CYC_INVALID || ct == dmc_pkg::CYC_BASIC) begin
                d.run[c] = 1'b0;
            end
        end

        unique case (q.state)
            // Arbitration point: load the winner's structure
            S_IDLE: begin
                if (grant) begin
                    d.cur = pick;
                    d.src = q.mem[gi + dmc_pkg::W_SRC];
                    d.dst = q.mem[gi + dmc_pkg::W_DST];
                    d.n   = q.mem[gi][dmc_pkg::NM1_MSB:dmc_pkg::NM1_LSB];
                    d.blk = '0;
                    d.swp[pick] = 1'b0;
                    // Auto and ping-pong keep asking for themselves until done
                    if (q.mem[gi][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB] != dmc_pkg::CYC_BASIC) begin
                        d.run[pick] = 1'b1;
                    end
                    d.state = S_RD;
                end
            end
            S_RD: begin
                d.mem_rd = 1'b1;
                d.maddr  = q.src;
                d.state  = S_HOLD;
            end
            // Read strobe is on the bus now; data arrives next cycle
            S_HOLD: begin
                d.state = S_WR;
            end
            S_WR: begin
                d.mem_wr = 1'b1;
                d.maddr  = q.dst;
                d.mwdata = MEM_RDATA;
                // Word-only transfers: both addresses step one word
                d.src    = q.src + dmc_pkg::WORD_STEP;
                d.dst    = q.dst + dmc_pkg::WORD_STEP;
                d.blk    = q.blk + 16'h1;
                // Write back so a later block resumes where this one stopped
                d.mem[ci + dmc_pkg::W_SRC] = d.src;
                d.mem[ci + dmc_pkg::W_DST] = d.dst;
                if (q.n == '0) begin
                    // Cycle complete: leftover block may have been short
                    d.mem[ci][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB] = dmc_pkg::CYC_INVALID;
                    d.done_p[q.cur] = 1'b1;
                    if (cyc == dmc_pkg::CYC_PINGPONG) begin
                        d.alt[q.cur] = ~q.alt[q.cur];
                    end else begin
                        d.run[q.cur] = 1'b0;
                    end
                    d.state = S_IDLE;
                end else begin
                    // Count down; the stored field follows so software sees progress
                    d.n = q.n - 10'h1;
                    d.mem[ci][dmc_pkg::NM1_MSB:dmc_pkg::NM1_LSB] = d.n;
                    if (d.blk == blksize(rpw)) begin
                        // A default channel with a big block holds off high ones until here
                        // Block end: re-arbitrate; basic needs a fresh request
                        if (cyc == dmc_pkg::CYC_BASIC) begin
                            d.run[q.cur] = 1'b0;
                        end
                        d.state = S_IDLE;
                    end else begin
                        d.state = S_RD;
                    end
                end
            end
        endcase

        // Hardware sets win over software clears
        d.done_st = d.done_st | d.done_p;
        if (REG_WR && REG_ADDR == dmc_pkg::REG_SWREQ) begin
            d.swp = d.swp | REG_WDATA[5:0];
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge CLK) begin
        if (RST) begin
            q         <= '0;
            q.state   <= S_IDLE;
            q.en      <= dmc_pkg::RST_CH6;
            q.mask    <= dmc_pkg::RST_CH6;
        end else begin
            q <= d;
        end
    end

    // ==================================================================
    // Outputs
    assign REG_RDATA = q.rdata;
    assign MEM_ADDR  = q.maddr;
    assign MEM_RD    = q.mem_rd;
    assign MEM_WR    = q.mem_wr;
    assign MEM_WDATA = q.mwdata;
    assign DMA_DONE  = q.done_p;
    assign IRQ       = |(q.done_st & q.mask);   // Level while an unmasked bit stands

    // ==================================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Completion pulse: one cycle, on the finishing channel, latched in status
    done_one_cycle_a: assert property (|DMA_DONE |=> DMA_DONE == '0)
        else $error("done pulse longer than one cycle");
    done_follows_fin_a: assert property (fin |=> DMA_DONE == (6'h1 << $past(q.cur)))
        else $error("completion did not pulse the channel done");
    done_sticky_a: assert property (|DMA_DONE |-> (q.done_st & DMA_DONE) == DMA_DONE)
        else $error("completion not held in done status");

    // Status read and interrupt line
    irq_on_done_a: assert property ((DMA_DONE & q.mask) != '0 |-> IRQ)
        else $error("unmasked completion missed interrupt");
    status_clear_a: assert property ((REG_RD && REG_ADDR == dmc_pkg::REG_DONE && !fin) |=> q.done_st == '0)
        else $error("done status not cleared by its read");
    rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == '0)
        else $error("read data shown without a read");

    // Spent structure must not run again
    invalid_wb_a: assert property (fin |=>
        q.mem[$past(ci)][dmc_pkg::CYC_MSB:dmc_pkg::CYC_LSB] == dmc_pkg::CYC_INVALID)
        else $error("completed structure not invalidated");

    // Bus order: one read, an idle cycle, then the write of that very word
    bus_excl_a: assert property (!(MEM_RD && MEM_WR))
        else $error("read and write strobes together");
    read_then_write_a: assert property (MEM_RD |=> !MEM_WR ##1
        (MEM_WR && MEM_WDATA == $past(MEM_RDATA)))
        else $error("read data not forwarded to write");

    // Arbitration: high level first, then the lowest number
    high_prio_a: assert property ((grant && hi != '0) |=> q.pri[q.cur])
        else $error("default channel granted over high");
    lowest_first_a: assert property (grant |-> (grp & ((6'h1 << pick) - 6'h1)) == '0)
        else $error("granted channel not the lowest number");

    // Software requests: the only start for channels without pins, spent by the grant
    sw_only_a: assert property ((grant && pick >= 3'h4 && !q.run[pick]) |-> q.swp[pick])
        else $error("pinless channel started without software");
    swreq_clear_a: assert property ((grant && !REG_WR) |=> !q.swp[$past(pick)])
        else $error("software request not spent by its grant");

    // Block bounds and what follows a block or cycle end
    block_bound_a: assert property (q.state != S_IDLE |-> q.blk < blksize(rpw))
        else $error("block ran past its size");
    basic_stop_a: assert property ((q.state == S_WR && q.n != '0 && cyc == dmc_pkg::CYC_BASIC
        && q.blk + 16'h1 == blksize(rpw)) |=> (!q.run[$past(q.cur)] && q.state == S_IDLE))
        else $error("basic cycle kept running without a request");
    auto_run_a: assert property ((q.state == S_WR && q.n != '0 && q.en[q.cur]
        && cyc == dmc_pkg::CYC_AUTO) |=> q.run[$past(q.cur)])
        else $error("auto cycle dropped its own request");
    pp_toggle_a: assert property ((fin && cyc == dmc_pkg::CYC_PINGPONG) |=>
        q.alt[$past(q.cur)] != $past(q.alt[q.cur]))
        else $error("ping-pong did not switch structure");
    run_stop_a: assert property ((q.run & ~q.en) != '0 |=> (q.run & ~$past(q.en)) == '0)
        else $error("disabled channel kept running");

    // Main scenarios: basic end, auto block end, ping-pong swap, preemption, pin start
    basic_done_c: cover property (fin && cyc == dmc_pkg::CYC_BASIC);
    auto_multi_c: cover property (q.state == S_WR && cyc == dmc_pkg::CYC_AUTO && q.n != '0
        && q.blk + 16'h1 == blksize(rpw));
    pingpong_swap_c: cover property (fin && cyc == dmc_pkg::CYC_PINGPONG ##[1:20] grant);
    preempt_c: cover property (grant && hi != '0 && want != hi);
    hw_start_c: cover property (grant && hw[pick] && !q.swp[pick]);
endmodule : dmc_dma_top

// ---- dv/dmc_mem_model.sv ----
// Zero-wait memory bus slave that feeds the controller's reads and keeps its writes
`timescale 1ns/1ps
module dmc_mem_model (
    input  wire logic        clk,   // System clock
    input  wire logic [31:0] addr,  // Bus address
    input  wire logic        rd,    // Read strobe
    input  wire logic        wr,    // Write strobe
    input  wire logic [31:0] wdata, // Write data
    output logic      [31:0] rdata  // Read data, cycle after rd; flips to its inverse each cycle without rd
);
    // ==================================================================
    // Storage, preset so every source word names its own index
    logic [31:0] mem [0:1023];

    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 32'h5a000000 | 32'(i);
        end
        rdata = 32'h0;
    end

    // Data stands one cycle, then flips to its inverse each cycle, so a sample one cycle late cannot pass
    always @(posedge clk) begin
        if (wr) begin
            mem[addr[11:2]] <= wdata;
        end
        if (rd) begin
            rdata <= mem[addr[11:2]];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule : dmc_mem_model

// ---- dv/dmc_dma_top_tb_top.sv ----
// Self-checking testbench for the six-channel DMA controller
`timescale 1ns/1ps
module dmc_dma_top_tb_top;
    // ==================================================================
    // Signals and bookkeeping
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr_s = 1'b0;
    logic        reg_rd_s = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  hw_req = 8'h0;
    logic [31:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic [5:0]  dma_done;
    logic [5:0]  prev_done = 6'h0;
    logic        irq;
    logic [31:0] rdv;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          wr_cnt = 0;
    int          done_cnt [6] = '{default: 0};
    int          done_q [$];
    int          t;
    int          t4;
    int          n;

    always #12.5 clk = ~clk;

    dmc_dma_top i_dmc_dma_top (
        .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr_s),
        .REG_RD(reg_rd_s), .REG_RDATA(reg_rdata),
        .SYNC_SERIAL_A_TX_REQUEST(hw_req[0]), .SYNC_SERIAL_A_RX_REQUEST(hw_req[1]),
        .SYNC_SERIAL_B_TX_REQUEST(hw_req[2]), .SYNC_SERIAL_B_RX_REQUEST(hw_req[3]),
        .SERIAL_PORT_A_TX_REQUEST(hw_req[4]), .SERIAL_PORT_A_RX_REQUEST(hw_req[5]),
        .SERIAL_PORT_B_TX_REQUEST(hw_req[6]), .SERIAL_PORT_B_RX_REQUEST(hw_req[7]),
        .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata),
        .MEM_RDATA(mem_rdata), .DMA_DONE(dma_done), .IRQ(irq));

    dmc_mem_model i_dmc_mem_model (.clk(clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr),
        .wdata(mem_wdata), .rdata(mem_rdata));

    // ==================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_s <= 1'b1;
        @(posedge clk);
        reg_wr_s <= 1'b0;
    endtask : reg_wr

    // Read data is taken just after the edge that registers it, the one cycle it stands
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_s <= 1'b1;
        @(posedge clk);
        reg_rd_s <= 1'b0;
        #1 rdv = reg_rdata;
        check(rdv, exp);
    endtask : rd_chk

    task automatic desc(input int ch, input int alt, input logic [1:0] cyc, input logic [3:0] r,
                        input logic [9:0] nm1, input logic [31:0] src, input logic [31:0] dst);
        logic [7:0] a;
        a = dmc_pkg::DESC_BASE + 8'((ch * 2 + alt) * 12);
        reg_wr(a, {16'h0, nm1, r, cyc});
        reg_wr(a + 8'h4, src);
        reg_wr(a + 8'h8, dst);
    endtask : desc

    // Bounded wait for a channel's completion count
    task automatic wait_cnt(input int ch, input int target);
        for (int i = 0; i < 3000 && done_cnt[ch] < target; i++) @(posedge clk);
        check(32'(done_cnt[ch]), 32'(target));
    endtask : wait_cnt

    // ==================================================================
    // Monitor: transfer and completion counts, pulse width, hang limit
    always @(posedge clk) begin
        cycles++;
        wr_cnt += (mem_wr === 1'b1) ? 1 : 0;
        for (int c = 0; c < 6; c++) if (dma_done[c] === 1'b1) begin
            done_cnt[c]++;
            done_q.push_back(c);
        end
        if (!rst && (dma_done & prev_done) != 6'h0) check({26'h0, dma_done & prev_done}, 32'h0);
        prev_done <= dma_done;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // ==================================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(dmc_pkg::REG_DONE, 32'h0);
        rd_chk(dmc_pkg::DESC_BASE, 32'h0);
        rd_chk(8'h30, 32'h0);
        reg_wr(dmc_pkg::REG_ENABLE, 32'h3f);
        reg_wr(dmc_pkg::REG_MASK, 32'h20);
        // Basic, N=3 in blocks of two: one block per request, leftover at the end
        wr_cnt = 0;
        desc(5, 0, dmc_pkg::CYC_BASIC, 4'h1, 10'h2, 32'h100, 32'h800);
        reg_wr(dmc_pkg::REG_SWREQ, 32'h20);
        repeat (60) @(posedge clk);
        check(32'(wr_cnt), 32'h2);
        check(32'(done_cnt[5]), 32'h0);
        reg_wr(dmc_pkg::REG_SWREQ, 32'h20);
        wait_cnt(5, 1);
        #2 check({31'h0, irq}, 32'h1);
        check(32'(wr_cnt), 32'h3);
        rd_chk(dmc_pkg::REG_DONE, 32'h20);
        check({31'h0, irq}, 32'h0);
        rd_chk(dmc_pkg::DESC_BASE + 8'h78, 32'h4);
        for (int k = 0; k < 3; k++) check(i_dmc_mem_model.mem[32'h200 + k], 32'h5a000040 + 32'(k));
        // Auto-request: one request carries the whole cycle; masked done keeps the line low
        desc(4, 0, dmc_pkg::CYC_AUTO, 4'h1, 10'h4, 32'h180, 32'h900);
        reg_wr(dmc_pkg::REG_SWREQ, 32'h10);
        wait_cnt(4, 1);
        #2 check({31'h0, irq}, 32'h0);
        rd_chk(dmc_pkg::REG_DONE, 32'h10);
        for (int k = 0; k < 5; k++) check(i_dmc_mem_model.mem[32'h240 + k], 32'h5a000060 + 32'(k));
        // Arbitration: equal levels, then channel five-of-six raised to high
        for (int p = 0; p < 2; p++) begin
            done_q.delete();
            t = done_cnt[2] + 1;
            t4 = done_cnt[4] + 1;
            desc(2, 0, dmc_pkg::CYC_AUTO, 4'h0, 10'h3, 32'h200, 32'ha00);
            desc(4, 0, dmc_pkg::CYC_AUTO, 4'h0, 10'h3, 32'h280, 32'hb00);
            reg_wr(dmc_pkg::REG_PRIO, (p == 1) ? 32'h10 : 32'h0);
            reg_wr(dmc_pkg::REG_SWREQ, 32'h14);
            wait_cnt(2, t);
            wait_cnt(4, t4);
            check(32'(done_q[0]), (p == 1) ? 32'h4 : 32'h2);
        end
        reg_wr(dmc_pkg::REG_PRIO, 32'h0);
        rd_chk(dmc_pkg::REG_DONE, 32'h14);
        // Every hardware request pin starts only its own channel; odd pins use the alternate set
        for (int i = 0; i < 8; i++) begin
            t = done_cnt[i / 2] + 1;
            n = done_q.size();
            desc(i / 2, i % 2, dmc_pkg::CYC_BASIC, 4'h0, 10'h0, 32'h300 + 32'(i * 4), 32'hc00 + 32'(i * 4));
            reg_wr(dmc_pkg::REG_ALT, 32'(i % 2) << (i / 2));
            hw_req[i] <= 1'b1;
            wait_cnt(i / 2, t);
            hw_req[i] <= 1'b0;
            repeat (20) @(posedge clk);
            check(32'(done_q.size()), 32'(n + 1));
        end
        // Ping-pong: primary then alternate, then stop on the spent primary
        t = done_cnt[3];
        desc(3, 0, dmc_pkg::CYC_PINGPONG, 4'h0, 10'h1, 32'h380, 32'hd00);
        desc(3, 1, dmc_pkg::CYC_PINGPONG, 4'h0, 10'h0, 32'h3c0, 32'he00);
        reg_wr(dmc_pkg::REG_ALT, 32'h0);
        reg_wr(dmc_pkg::REG_SWREQ, 32'h8);
        wait_cnt(3, t + 2);
        repeat (50) @(posedge clk);
        check(32'(done_cnt[3]), 32'(t + 2));
        rd_chk(dmc_pkg::REG_ALT, 32'h0);
        check(i_dmc_mem_model.mem[32'h380], 32'h5a0000f0);
        // A request on a channel whose structure is invalid moves nothing
        reg_wr(dmc_pkg::REG_SWREQ, 32'h8);
        repeat (50) @(posedge clk);
        check(32'(done_cnt[3]), 32'(t + 2));
        rd_chk(dmc_pkg::REG_SWREQ, 32'h8);
        rd_chk(dmc_pkg::REG_STATUS, 32'h3);
        test_done();
    end
endmodule : dmc_dma_top_tb_top
